/* File: hwt_pkg.sv */
// shared constants and carriers for the haptic waveform tuning bank
package hwt_pkg;

  localparam int REG_NUM = 6;

  // slots of the register array
  localparam int SLOT_NEG_SUS = 0;
  localparam int SLOT_BRAKE = 1;
  localparam int SLOT_RATED = 2;
  localparam int SLOT_LIMIT = 3;
  localparam int SLOT_COMP = 4;
  localparam int SLOT_BEMF = 5;

  // register index; byte address is four times the index
  localparam logic [7:0] IDX_NEG_SUSTAIN_TIME_OFFSET = 8'h1C;
  localparam logic [7:0] IDX_BRAKE_TIME_OFFSET = 8'h1D;
  localparam logic [7:0] IDX_FULL_SCALE_VOLTAGE_REF = 8'h1F;
  localparam logic [7:0] IDX_BOOST_VOLTAGE_LIMIT = 8'h20;
  localparam logic [7:0] IDX_LOSS_COMPENSATION_RESULT = 8'h21;
  localparam logic [7:0] IDX_BACKEMF_GAIN_RESULT = 8'h22;
  localparam logic [7:0] REG_IDX [REG_NUM] = '{
    IDX_NEG_SUSTAIN_TIME_OFFSET, IDX_BRAKE_TIME_OFFSET,
    IDX_FULL_SCALE_VOLTAGE_REF, IDX_BOOST_VOLTAGE_LIMIT,
    IDX_LOSS_COMPENSATION_RESULT, IDX_BACKEMF_GAIN_RESULT};

  localparam logic [7:0] RST_NEG_SUSTAIN_TIME_OFFSET = 8'h00;
  localparam logic [7:0] RST_BRAKE_TIME_OFFSET = 8'h00;
  localparam logic [7:0] RST_FULL_SCALE_VOLTAGE_REF = 8'h3F;
  localparam logic [7:0] RST_BOOST_VOLTAGE_LIMIT = 8'h89;
  localparam logic [7:0] RST_LOSS_COMPENSATION_RESULT = 8'h0D;
  localparam logic [7:0] RST_BACKEMF_GAIN_RESULT = 8'h6D;
  localparam logic [7:0] REG_RST [REG_NUM] = '{
    RST_NEG_SUSTAIN_TIME_OFFSET, RST_BRAKE_TIME_OFFSET,
    RST_FULL_SCALE_VOLTAGE_REF, RST_BOOST_VOLTAGE_LIMIT,
    RST_LOSS_COMPENSATION_RESULT, RST_BACKEMF_GAIN_RESULT};

  localparam logic [1:0] AXI_RESP_OKAY = 2'h0;
  localparam logic [1:0] AXI_RESP_SLVERR = 2'h2;
  localparam logic [15:0] DUR_MAX = 16'hFFFF;

  typedef enum logic [2:0] {
    SEG_OTHER = 3'b001,
    SEG_NEG_SUSTAIN = 3'b010,
    SEG_BRAKE = 3'b100
  } hwt_seg_kind_e;

  typedef enum logic [1:0] {
    WR_IDLE = 2'b01,
    WR_RESP = 2'b10
  } hwt_wr_state_e;

  // one library waveform segment offered for timing adjustment
  typedef struct packed {
    logic valid;
    logic signed [7:0] level;
    logic is_overdrive;
    logic [15:0] dur_ms;
  } hwt_seg_s;

  typedef struct packed {
    logic valid;
    hwt_seg_kind_e kind;
    logic [15:0] dur_ms;
  } hwt_seg_res_s;

  // closed-loop drive magnitude request
  typedef struct packed {
    logic valid;
    logic boost;
    logic [7:0] mag;
  } hwt_drv_s;

endpackage

/* File: hwt_regs.sv */
// haptic waveform tuning registers with segment timing and drive limiting
//
// Chosen here: the AXI4-Lite register port.
`timescale 1ns/100ps

module hwt_regs
  import hwt_pkg::*;
#(
  parameter int AXI_ADDR_W = 10,
  parameter int PERIOD_W = 8
) (
  // clock and reset
  input wire logic clk,
  input wire logic nrst,
  // axi4-lite write address and data
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [AXI_ADDR_W-1:0] s_axi_awaddr,
  input wire logic [2:0] s_axi_awprot,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  // axi4-lite write response
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  output logic [1:0] s_axi_bresp,
  // axi4-lite read
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  input wire logic [AXI_ADDR_W-1:0] s_axi_araddr,
  input wire logic [2:0] s_axi_arprot,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  // playback engine side
  input wire logic closed_loop,
  input wire logic [PERIOD_W-1:0] sample_step_period,
  input wire logic signed [7:0] wave_min_level,
  input wire hwt_seg_s seg_in,
  output hwt_seg_res_s seg_out,
  input wire hwt_drv_s drv_in,
  output logic drive_valid,
  output logic [7:0] drive_mag,
  output logic [7:0] feedback_gain,
  // calibration engine side
  input wire logic cal_done,
  input wire logic [7:0] cal_impedance,
  input wire logic [7:0] cal_bemf
);

  localparam int PROD_W = PERIOD_W + 9;
  localparam int SUM_W = PROD_W + 2;

  logic [7:0] regs_ff [REG_NUM];
  logic [AXI_ADDR_W-1:0] aw_addr_ff;
  logic aw_got_ff;
  logic [7:0] w_data_ff;
  logic w_lane0_ff;
  logic w_got_ff;
  hwt_wr_state_e wr_state_ff;
  logic wr_commit;
  logic [REG_NUM-1:0] wr_sel;
  logic [REG_NUM-1:0] rd_sel;
  logic [REG_NUM-1:0] cal_load;
  logic [7:0] cal_value [REG_NUM];
  logic bvalid_ff;
  logic [1:0] bresp_ff;
  logic rvalid_ff;
  logic [31:0] rdata_ff;
  logic [1:0] rresp_ff;
  logic [7:0] rd_byte;
  hwt_seg_res_s seg_out_ff;
  hwt_seg_kind_e nxt_kind;
  logic [15:0] nxt_dur;
  logic signed [7:0] sel_offset;
  logic signed [PROD_W-1:0] offset_ms;
  logic signed [SUM_W-1:0] dur_sum;
  logic drive_valid_ff;
  logic [7:0] drive_mag_ff;
  logic [7:0] nxt_mag;
  logic [7:0] mag_cap;
  logic [7:0] feedback_gain_ff;

  // one-hot register select, shared by read and write decode
  function automatic logic [REG_NUM-1:0] reg_select(
    input logic [AXI_ADDR_W-1:0] addr
  );
    logic [REG_NUM-1:0] sel;
    sel = '0;
    for (int i = 0; i < REG_NUM; i++) begin
      sel[i] = (addr[AXI_ADDR_W-1:2] == (AXI_ADDR_W-2)'(REG_IDX[i])) &&
               (addr[1:0] == 2'h0);
    end
    return sel;
  endfunction

  ////////////////////////////////////////////////////////////////////////
  // write channel

  assign s_axi_awready = (wr_state_ff == WR_IDLE) && !aw_got_ff;
  assign s_axi_wready = (wr_state_ff == WR_IDLE) && !w_got_ff;
  assign wr_commit = (wr_state_ff == WR_IDLE) && aw_got_ff && w_got_ff;
  assign wr_sel = reg_select(aw_addr_ff);

  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      aw_got_ff <= 1'b0;
      aw_addr_ff <= '0;
    end else if (s_axi_awvalid && s_axi_awready) begin
      aw_got_ff <= 1'b1;
      aw_addr_ff <= s_axi_awaddr;
    end else if (wr_commit) begin
      aw_got_ff <= 1'b0;
    end
  end

  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      w_got_ff <= 1'b0;
      w_data_ff <= 8'h00;
      w_lane0_ff <= 1'b0;
    end else if (s_axi_wvalid && s_axi_wready) begin
      w_got_ff <= 1'b1;
      w_data_ff <= s_axi_wdata[7:0];
      w_lane0_ff <= s_axi_wstrb[0];
    end else if (wr_commit) begin
      w_got_ff <= 1'b0;
    end
  end

  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      wr_state_ff <= WR_IDLE;
      bvalid_ff <= 1'b0;
      bresp_ff <= AXI_RESP_OKAY;
    end else begin
      case (wr_state_ff)
        WR_IDLE: begin
          if (wr_commit) begin
            wr_state_ff <= WR_RESP;
            bvalid_ff <= 1'b1;
            bresp_ff <= (|wr_sel) ? AXI_RESP_OKAY : AXI_RESP_SLVERR;
          end
        end
        WR_RESP: begin
          if (s_axi_bready) begin
            wr_state_ff <= WR_IDLE;
            bvalid_ff <= 1'b0;
          end
        end
        default: begin
          wr_state_ff <= WR_IDLE;
          bvalid_ff <= 1'b0;
        end
      endcase
    end
  end

  assign s_axi_bvalid = bvalid_ff;
  assign s_axi_bresp = bresp_ff;

  ////////////////////////////////////////////////////////////////////////
  // register storage

  // loss compensation follows the measured impedance directly
  always_comb begin
    cal_load = '0;
    for (int i = 0; i < REG_NUM; i++) begin
      cal_value[i] = 8'h00;
    end
    cal_load[SLOT_COMP] = cal_done;
    cal_value[SLOT_COMP] = cal_impedance;
    cal_load[SLOT_BEMF] = cal_done;
    cal_value[SLOT_BEMF] = cal_bemf;
  end

  // calibration wins over a software write landing in the same cycle
  for (genvar g = 0; g < REG_NUM; g++) begin : g_reg
    always_ff @(posedge clk or negedge nrst) begin
      if (!nrst) begin
        regs_ff[g] <= REG_RST[g];
      end else if (cal_load[g]) begin
        regs_ff[g] <= cal_value[g];
      end else if (wr_commit && wr_sel[g] && w_lane0_ff) begin
        regs_ff[g] <= w_data_ff;
      end
    end
  end

  reg_store_a: assert property (@(posedge clk) disable iff (!nrst)
    wr_commit && w_lane0_ff && wr_sel[SLOT_LIMIT] |=>
      regs_ff[SLOT_LIMIT] == $past(w_data_ff))
    else $error("limit register did not take written byte");

  cal_result_a: assert property (@(posedge clk) disable iff (!nrst)
    cal_done |=> regs_ff[SLOT_COMP] == $past(cal_impedance) &&
      regs_ff[SLOT_BEMF] == $past(cal_bemf))
    else $error("calibration results not stored");

  ////////////////////////////////////////////////////////////////////////
  // read channel

  assign rd_sel = reg_select(s_axi_araddr);
  assign s_axi_arready = !rvalid_ff;

  always_comb begin
    rd_byte = 8'h00;
    for (int i = 0; i < REG_NUM; i++) begin
      if (rd_sel[i]) begin
        rd_byte = regs_ff[i];
      end
    end
  end

  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      rvalid_ff <= 1'b0;
      rdata_ff <= 32'h0000_0000;
      rresp_ff <= AXI_RESP_OKAY;
    end else if (s_axi_arvalid && s_axi_arready) begin
      rvalid_ff <= 1'b1;
      rdata_ff <= {24'h00_0000, rd_byte};
      rresp_ff <= (|rd_sel) ? AXI_RESP_OKAY : AXI_RESP_SLVERR;
    end else if (s_axi_rready) begin
      rvalid_ff <= 1'b0;
    end
  end

  assign s_axi_rvalid = rvalid_ff;
  assign s_axi_rdata = rdata_ff;
  assign s_axi_rresp = rresp_ff;

  rd_hold_a: assert property (@(posedge clk) disable iff (!nrst)
    rvalid_ff && !s_axi_rready |=> rvalid_ff && $stable(rdata_ff))
    else $error("read data dropped before accept");

  wr_resp_a: assert property (@(posedge clk) disable iff (!nrst)
    wr_commit |=> bvalid_ff ##0 (wr_state_ff == WR_RESP))
    else $error("write response missing after commit");

  ////////////////////////////////////////////////////////////////////////
  // segment timing adjustment

  // brake takes precedence: the lowest level is also a negative level
  always_comb begin
    nxt_kind = SEG_OTHER;
    sel_offset = 8'sh00;
    if (!seg_in.is_overdrive && seg_in.level < 0) begin
      if (seg_in.level == wave_min_level) begin
        nxt_kind = SEG_BRAKE;
        // closed loop brakes on its own
        if (!closed_loop) begin
          sel_offset = signed'(regs_ff[SLOT_BRAKE]);
        end
      end else begin
        nxt_kind = SEG_NEG_SUSTAIN;
        sel_offset = signed'(regs_ff[SLOT_NEG_SUS]);
      end
    end
  end

  // widen both factors first so the full product survives
  assign offset_ms = signed'(PROD_W'(sel_offset)) *
                     signed'(PROD_W'({1'b0, sample_step_period}));
  assign dur_sum = signed'(SUM_W'({1'b0, seg_in.dur_ms})) +
                   SUM_W'(offset_ms);

  // a segment can shrink to nothing but never goes negative
  always_comb begin
    if (dur_sum < 0) begin
      nxt_dur = 16'h0000;
    end else if (dur_sum > signed'(SUM_W'({1'b0, DUR_MAX}))) begin
      nxt_dur = DUR_MAX;
    end else begin
      nxt_dur = dur_sum[15:0];
    end
  end

  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      seg_out_ff <= '{valid: 1'b0, kind: SEG_OTHER, dur_ms: 16'h0000};
    end else begin
      seg_out_ff.valid <= seg_in.valid;
      if (seg_in.valid) begin
        seg_out_ff.kind <= nxt_kind;
        seg_out_ff.dur_ms <= nxt_dur;
      end
    end
  end

  assign seg_out = seg_out_ff;

  neg_sus_kind_a: assert property (@(posedge clk) disable iff (!nrst)
    seg_in.valid && seg_in.level < 0 && !seg_in.is_overdrive &&
      seg_in.level != wave_min_level |=> seg_out_ff.kind == SEG_NEG_SUSTAIN)
    else $error("negative level not classed as sustain");

  od_kind_a: assert property (@(posedge clk) disable iff (!nrst)
    seg_in.valid && seg_in.is_overdrive |=> seg_out_ff.kind == SEG_OTHER)
    else $error("overdrive segment misclassified");

  brake_closed_a: assert property (@(posedge clk) disable iff (!nrst)
    seg_in.valid && closed_loop && !seg_in.is_overdrive &&
      seg_in.level < 0 && seg_in.level == wave_min_level |=>
      seg_out_ff.kind == SEG_BRAKE && seg_out_ff.dur_ms == $past(seg_in.dur_ms))
    else $error("brake offset applied in closed loop");

  sus_lengthen_a: assert property (@(posedge clk) disable iff (!nrst)
    seg_in.valid && nxt_kind == SEG_NEG_SUSTAIN &&
      regs_ff[SLOT_NEG_SUS] == 8'h01 && seg_in.dur_ms < 16'hFF00 |=>
      seg_out_ff.dur_ms == $past(seg_in.dur_ms) +
        16'($past(sample_step_period)))
    else $error("sustain offset of one step not applied");

  ////////////////////////////////////////////////////////////////////////
  // closed-loop drive limiting

  // boost periods may rise above rated, up to the limit register
  always_comb begin
    mag_cap = drv_in.boost ? regs_ff[SLOT_LIMIT] : regs_ff[SLOT_RATED];
    nxt_mag = drv_in.mag;
    if (closed_loop && drv_in.mag > mag_cap) begin
      nxt_mag = mag_cap;
    end
  end

  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      drive_valid_ff <= 1'b0;
      drive_mag_ff <= 8'h00;
    end else begin
      drive_valid_ff <= drv_in.valid;
      if (drv_in.valid) begin
        drive_mag_ff <= nxt_mag;
      end
    end
  end

  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      feedback_gain_ff <= RST_BACKEMF_GAIN_RESULT;
    end else begin
      feedback_gain_ff <= regs_ff[SLOT_BEMF];
    end
  end

  assign drive_valid = drive_valid_ff;
  assign drive_mag = drive_mag_ff;
  assign feedback_gain = feedback_gain_ff;

  rated_cap_a: assert property (@(posedge clk) disable iff (!nrst)
    drv_in.valid && closed_loop && !drv_in.boost ##1
      $stable(regs_ff[SLOT_RATED]) |->
      drive_mag_ff <= regs_ff[SLOT_RATED])
    else $error("drive above rated outside boost");

  boost_cap_a: assert property (@(posedge clk) disable iff (!nrst)
    drv_in.valid && closed_loop && drv_in.boost |=>
      drive_mag_ff == (($past(drv_in.mag) > $past(regs_ff[SLOT_LIMIT])) ?
        $past(regs_ff[SLOT_LIMIT]) : $past(drv_in.mag)))
    else $error("boost drive not limited to clamp");

  fb_gain_a: assert property (@(posedge clk) disable iff (!nrst)
    cal_done |-> ##2 feedback_gain_ff == $past(cal_bemf, 2))
    else $error("feedback gain does not follow calibration");

endmodule

/* File: hwt_actuator_model.sv */
// actuator and measurement front end seen by the tuning bank
`timescale 1ns/100ps
module hwt_actuator_model #(
  parameter logic [7:0] IMP_CODE = 8'h2A,
  parameter logic [7:0] BEMF_CODE = 8'h5C
) (
  // clock and reset
  input wire logic clk,
  input wire logic nrst,
  // calibration request and results
  input wire logic cal_start,
  input wire logic [7:0] cal_delay,
  output logic cal_done,
  output logic [7:0] cal_impedance,
  output logic [7:0] cal_bemf,
  // drive reaching the coil
  input wire logic drive_valid,
  input wire logic [7:0] drive_mag,
  output logic [7:0] last_mag
);
  logic [7:0] cnt_ff;
  logic [7:0] mag_ff;

  // delay of 1 answers at once, larger values model a slow measurement
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      cnt_ff <= 8'h00;
      cal_done <= 1'b0;
    end else begin
      cal_done <= (cnt_ff == 8'h01);
      if (cal_start) begin
        cnt_ff <= cal_delay;
      end else if (cnt_ff != 8'h00) begin
        cnt_ff <= cnt_ff - 8'h01;
      end
    end
  end

  // results only valid with the strobe; inverted otherwise, not held
  assign cal_impedance = cal_done ? IMP_CODE : ~IMP_CODE;
  assign cal_bemf = cal_done ? BEMF_CODE : ~BEMF_CODE;

  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      mag_ff <= 8'h00;
    end else if (drive_valid) begin
      mag_ff <= drive_mag;
    end
  end
  assign last_mag = mag_ff;
endmodule

/* File: tb_top.sv */
// self-checking bench for the haptic waveform tuning bank
`timescale 1ns/100ps
module tb_top;
  import hwt_pkg::*;
  localparam logic [7:0] ACT_IMP = 8'h2A;
  localparam logic [7:0] ACT_BEMF = 8'h5C;
  logic clk, nrst, awvalid, wvalid, bready, arvalid, rready;
  logic awready, wready, bvalid, arready, rvalid;
  logic [9:0] awaddr, araddr;
  logic [31:0] wdata, rdata, rd;
  logic [3:0] wstrb;
  logic [1:0] bresp, rresp, rsp;
  logic closed_loop, drive_valid, cal_done, cal_start;
  logic [7:0] period, drive_mag, feedback_gain, cal_imp, cal_bemf;
  logic [7:0] cal_delay, last_mag;
  logic signed [7:0] wave_min;
  hwt_seg_s seg_in;
  hwt_seg_res_s seg_out;
  hwt_drv_s drv_in;
  int error_cnt, compares, cycles;

  hwt_regs #(.AXI_ADDR_W(10), .PERIOD_W(8)) DUT (
    .clk(clk), .nrst(nrst),
    .s_axi_awvalid(awvalid), .s_axi_awready(awready),
    .s_axi_awaddr(awaddr), .s_axi_awprot(3'h0),
    .s_axi_wvalid(wvalid), .s_axi_wready(wready),
    .s_axi_wdata(wdata), .s_axi_wstrb(wstrb),
    .s_axi_bvalid(bvalid), .s_axi_bready(bready), .s_axi_bresp(bresp),
    .s_axi_arvalid(arvalid), .s_axi_arready(arready),
    .s_axi_araddr(araddr), .s_axi_arprot(3'h0),
    .s_axi_rvalid(rvalid), .s_axi_rready(rready),
    .s_axi_rdata(rdata), .s_axi_rresp(rresp),
    .closed_loop(closed_loop), .sample_step_period(period),
    .wave_min_level(wave_min), .seg_in(seg_in), .seg_out(seg_out),
    .drv_in(drv_in), .drive_valid(drive_valid), .drive_mag(drive_mag),
    .feedback_gain(feedback_gain), .cal_done(cal_done),
    .cal_impedance(cal_imp), .cal_bemf(cal_bemf));

  hwt_actuator_model #(.IMP_CODE(ACT_IMP), .BEMF_CODE(ACT_BEMF)) u_act (
    .clk(clk), .nrst(nrst), .cal_start(cal_start), .cal_delay(cal_delay),
    .cal_done(cal_done), .cal_impedance(cal_imp), .cal_bemf(cal_bemf),
    .drive_valid(drive_valid), .drive_mag(drive_mag),
    .last_mag(last_mag));

  initial begin
    clk = 1'b0;
    forever #4 clk = ~clk;
  end

  ////////////////////////////////////////////////////////////////////////////
  task stop_test;
    $display("compares %0d error_cnt %0d", compares, error_cnt);
    if (error_cnt == 0 && compares > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask

  task automatic chk(input string nm, input logic [31:0] seen, exp);
    compares++;
    if (seen !== exp) begin
      error_cnt++;
      $display("CHECK FAILED %s exp %0h seen %0h", nm, exp, seen);
    end
  endtask

  // safety net well above the few hundred cycles the run needs
  always @(posedge clk) begin
    cycles++;
    if (cycles == 20000) begin
      error_cnt++;
      stop_test;
    end
  end

  task automatic axi_wr(input logic [9:0] a, input logic [31:0] d,
                        output logic [1:0] r);
    @(posedge clk);
    awvalid <= 1'b1;
    awaddr <= a;
    wvalid <= 1'b1;
    wdata <= d;
    wstrb <= 4'hF;
    bready <= 1'b1;
    do begin
      @(posedge clk);
      if (awvalid && awready) awvalid <= 1'b0;
      if (wvalid && wready) wvalid <= 1'b0;
    end while (bvalid !== 1'b1);
    r = bresp;
    bready <= 1'b0;
  endtask

  task automatic axi_rd(input logic [9:0] a, output logic [31:0] d,
                        output logic [1:0] r);
    @(posedge clk);
    arvalid <= 1'b1;
    araddr <= a;
    rready <= 1'b1;
    do begin
      @(posedge clk);
      if (arvalid && arready) arvalid <= 1'b0;
    end while (rvalid !== 1'b1);
    d = rdata;
    r = rresp;
    rready <= 1'b0;
  endtask

  task automatic seg(input logic signed [7:0] lv, input logic od,
                     input logic [15:0] du, input hwt_seg_kind_e k,
                     input logic [15:0] de);
    @(posedge clk);
    seg_in <= '{valid:1'b1, level:lv, is_overdrive:od, dur_ms:du};
    @(posedge clk);
    seg_in.valid <= 1'b0;
    @(posedge clk);
    chk("seg valid", seg_out.valid, 1'b1);
    chk("seg kind", seg_out.kind, k);
    chk("seg dur", seg_out.dur_ms, de);
  endtask

  task automatic drv(input logic b, input logic [7:0] m, e);
    @(posedge clk);
    drv_in <= '{valid:1'b1, boost:b, mag:m};
    @(posedge clk);
    drv_in.valid <= 1'b0;
    @(posedge clk);
    chk("drive valid", drive_valid, 1'b1);
    chk("drive mag", drive_mag, e);
    @(posedge clk);
    chk("coil mag", last_mag, e);
  endtask

  task automatic calib(input logic [7:0] dl);
    int n;
    @(posedge clk);
    cal_delay <= dl;
    cal_start <= 1'b1;
    @(posedge clk);
    cal_start <= 1'b0;
    n = 0;
    while (cal_done !== 1'b1 && n < 300) begin
      @(posedge clk);
      n++;
    end
    repeat (2) @(posedge clk);
    chk("gain", feedback_gain, ACT_BEMF);
    axi_rd(10'h084, rd, rsp);
    chk("comp", rd, {24'h0, ACT_IMP});
    axi_rd(10'h088, rd, rsp);
    chk("bemf", rd, {24'h0, ACT_BEMF});
  endtask

  ////////////////////////////////////////////////////////////////////////////
  task automatic t_reset;
    chk("gain rst", feedback_gain, RST_BACKEMF_GAIN_RESULT);
    for (int i = 0; i < REG_NUM; i++) begin
      axi_rd({REG_IDX[i], 2'h0}, rd, rsp);
      chk("rst val", rd, {24'h0, REG_RST[i]});
      chk("rst resp", rsp, AXI_RESP_OKAY);
    end
    axi_rd(10'h3F0, rd, rsp);
    chk("unmapped rd", rsp, AXI_RESP_SLVERR);
  endtask

  // upper bits written as ones must read back as zero
  task automatic t_rw;
    for (int i = 0; i < REG_NUM; i++) begin
      axi_wr({REG_IDX[i], 2'h0}, {24'hFFFFFF, 8'hA5 ^ 8'(i)}, rsp);
      chk("wr resp", rsp, AXI_RESP_OKAY);
    end
    for (int i = 0; i < REG_NUM; i++) begin
      axi_rd({REG_IDX[i], 2'h0}, rd, rsp);
      chk("rw val", rd, {24'h0, 8'hA5 ^ 8'(i)});
    end
    axi_wr(10'h3FC, 32'h11, rsp);
    chk("unmapped wr", rsp, AXI_RESP_SLVERR);
  endtask

  task automatic t_seg;
    axi_wr(10'h070, 32'hFE, rsp);
    axi_wr(10'h074, 32'h05, rsp);
    period <= 8'h03;
    wave_min <= -8'sd100;
    closed_loop <= 1'b0;
    seg(-8'sd5, 1'b0, 16'd20, SEG_NEG_SUSTAIN, 16'd14);
    seg(-8'sd5, 1'b0, 16'd4, SEG_NEG_SUSTAIN, 16'h0000);
    seg(-8'sd90, 1'b1, 16'd20, SEG_OTHER, 16'd20);
    seg(-8'sd100, 1'b0, 16'd20, SEG_BRAKE, 16'd35);
    seg(8'sd40, 1'b0, 16'd20, SEG_OTHER, 16'd20);
    closed_loop <= 1'b1;
    seg(-8'sd100, 1'b0, 16'd20, SEG_BRAKE, 16'd20);
    // offset of one step lengthens sustain by one period
    axi_wr(10'h070, 32'h01, rsp);
    seg(-8'sd5, 1'b0, 16'd20, SEG_NEG_SUSTAIN, 16'd23);
    // large negative offset times large period clamps at zero
    axi_wr(10'h070, 32'h80, rsp);
    period <= 8'hFF;
    seg(-8'sd5, 1'b0, 16'd30000, SEG_NEG_SUSTAIN, 16'd0);
    period <= 8'h03;
  endtask

  task automatic t_drive;
    axi_wr(10'h07C, 32'h40, rsp);
    axi_wr(10'h080, 32'h89, rsp);
    closed_loop <= 1'b1;
    drv(1'b0, 8'h50, 8'h40);
    drv(1'b1, 8'hA0, 8'h89);
    drv(1'b1, 8'h70, 8'h70);
    closed_loop <= 1'b0;
    drv(1'b0, 8'hF0, 8'hF0);
  endtask

  initial begin
    nrst = 1'b0;
    {awvalid, wvalid, bready, arvalid, rready} = 5'h00;
    awaddr = 10'h000;
    araddr = 10'h000;
    wdata = 32'h0;
    wstrb = 4'h0;
    closed_loop = 1'b0;
    period = 8'h00;
    wave_min = 8'sd0;
    seg_in = '0;
    drv_in = '0;
    cal_start = 1'b0;
    cal_delay = 8'h01;
    repeat (10) @(posedge clk);
    nrst <= 1'b1;
    t_reset;
    t_rw;
    t_seg;
    t_drive;
    calib(8'h01);
    axi_wr(10'h07C, 32'h50, rsp);
    calib(8'h14);
    stop_test;
  end
endmodule
